// [core/flash_lock_host.sv]
// host sequencer for lock-bit set, clear-all, status check and recovery
// assumes the flash pins of one 8-bit flash device
`timescale 1ns/1ps
`default_nettype none
module flash_lock_host
    import flash_lock_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    // user command port
    input  wire logic                opValid,
    output logic                     opReady,
    input  wire logic [1:0]          opCode,
    input  wire logic [flash_lock_pkg::ADDR_W-1:0] opAddr,
    // user result
    output logic                     resValid,
    output logic [7:0]               resStatus,
    output logic                     errSequence,
    output logic                     errProgram,
    output logic                     errUnlock,
    output logic                     errSupply,
    output logic                     errProtect,
    output logic                     errPending,
    // flash pins
    output logic [flash_lock_pkg::ADDR_W-1:0] flashAddr,
    output logic                     flashCe_n,
    output logic                     flashWe_n,
    output logic                     flashOe_n,
    input  wire logic [7:0]          flashDataIn,
    output logic [7:0]               flashDataOut,
    output logic                     flashDataOe
);
    import flash_lock_pkg::*;

    typedef enum logic [7:0] {
        S_IDLE   = 8'b00000001,
        S_SETUP  = 8'b00000010,
        S_CONF   = 8'b00000100,
        S_POLL   = 8'b00001000,
        S_CHECK  = 8'b00010000,
        S_CLRST  = 8'b00100000,
        S_ARRAY  = 8'b01000000,
        S_RSTAT  = 8'b10000000
    } seq_e;

    seq_e              state, next_state;
    logic [1:0]        op, next_op;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [7:0]        status, next_status;
    logic              pend, next_pend;
    logic              rv, next_rv;

    flash_cycle_if cyc ();

    flash_bus_cycle u_cycle (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .cyc          (cyc),
        .flashAddr    (flashAddr),
        .flashCe_n    (flashCe_n),
        .flashWe_n    (flashWe_n),
        .flashOe_n    (flashOe_n),
        .flashDataIn  (flashDataIn),
        .flashDataOut (flashDataOut),
        .flashDataOe  (flashDataOe)
    );

    always_comb begin
        next_state  = state;
        next_op     = op;
        next_addr   = addr;
        next_status = status;
        next_pend   = pend;
        next_rv     = 1'b0;
        cyc.req     = 1'b0;
        cyc.isWrite = 1'b1;
        cyc.addr    = addr;
        cyc.wdata   = CMD_LOCK_SETUP;
        case (state)
            S_IDLE: begin
                if (opValid) begin
                    next_op   = opCode;
                    next_addr = opAddr;
                    case (opCode)
                        OP_CLEAR_STAT: next_state = S_CLRST;
                        OP_READ_ARRAY: next_state = S_ARRAY;
                        default:       next_state = S_SETUP;
                    endcase
                end
            end
            S_SETUP: begin
                cyc.req   = 1'b1;
                cyc.wdata = CMD_LOCK_SETUP;
                if (cyc.done)
                    next_state = S_CONF;
            end
            S_CONF: begin
                cyc.req   = 1'b1;
                cyc.wdata = (op == OP_SET_LOCK) ? CMD_LOCK_SET
                                                : CMD_LOCK_CLR_ALL;
                if (cyc.done)
                    next_state = S_POLL;
            end
            S_POLL: begin
                cyc.req     = 1'b1;
                cyc.isWrite = 1'b0;
                if (cyc.done) begin
                    next_status = cyc.rdata;
                    if (cyc.rdata[BIT_READY])
                        next_state = S_CHECK;
                end
            end
            S_CHECK: begin
                next_rv    = 1'b1;
                next_state = S_IDLE;
                // flags accumulate; only clear-status drops pend
                next_pend  = pend | status[BIT_UNLOCK] | status[BIT_PROGRAM]
                           | status[BIT_SUPPLY] | status[BIT_PROTECT];
            end
            S_CLRST: begin
                cyc.req   = 1'b1;
                cyc.wdata = CMD_CLEAR_STATUS;
                if (cyc.done) begin
                    next_pend  = 1'b0;
                    next_state = S_RSTAT;
                end
            end
            S_RSTAT: begin
                cyc.req   = 1'b1;
                cyc.wdata = CMD_READ_STATUS;
                if (cyc.done)
                    next_state = S_POLL;
            end
            S_ARRAY: begin
                cyc.req   = 1'b1;
                cyc.wdata = CMD_READ_ARRAY;
                if (cyc.done) begin
                    next_state = S_IDLE;
                    next_rv    = 1'b1;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state  <= S_IDLE;
            op     <= OP_SET_LOCK;
            addr   <= '0;
            status <= 8'h00;
            pend   <= 1'b0;
            rv     <= 1'b0;
        end else begin
            state  <= next_state;
            op     <= next_op;
            addr   <= next_addr;
            status <= next_status;
            pend   <= next_pend;
            rv     <= next_rv;
        end
    end

    assign opReady   = (state == S_IDLE);
    assign resValid  = rv;
    assign resStatus = status;
    assign errPending = pend;
    // decode of bits 5, 4, 3 and 1
    assign errSequence = status[BIT_UNLOCK] & status[BIT_PROGRAM];
    assign errProgram  = status[BIT_PROGRAM] & ~status[BIT_UNLOCK];
    assign errUnlock   = status[BIT_UNLOCK] & ~status[BIT_PROGRAM];
    assign errSupply   = status[BIT_SUPPLY];
    assign errProtect  = status[BIT_PROTECT];

    poll_ready_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        $rose(resValid) && $past(state) == S_CHECK |-> resStatus[BIT_READY])
        else $error("result given before device ready");
    seq_decode_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        errSequence |-> !errProgram && !errUnlock)
        else $error("sequence error also decoded as fail");
    setup_code_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        $fell(flashWe_n) && state == S_SETUP
        |-> flashDataOut == 8'h60 && flashAddr == addr)
        else $error("setup code wrong");
    confirm_code_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        $fell(flashWe_n) && state == S_CONF
        |-> flashDataOut == (op == OP_SET_LOCK ? 8'h01 : 8'hD0))
        else $error("confirm code wrong");
    pend_sticky_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        pend && !(state == S_CLRST && cyc.done) |=> pend)
        else $error("pending error dropped");
    array_cmd_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        $fell(flashWe_n) && state == S_ARRAY |-> flashDataOut == 8'hFF)
        else $error("read array code wrong");
    clear_pend_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        state == S_CLRST && cyc.done |=> !pend)
        else $error("pending not cleared");
    pend_set_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        state == S_CHECK && status[BIT_SUPPLY] |=> pend)
        else $error("supply fault not recorded");
    pend_fault_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        state == S_CHECK && (status[BIT_UNLOCK] || status[BIT_PROGRAM]
        || status[BIT_PROTECT]) |=> pend)
        else $error("fault not recorded");
    clear_cmd_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        $fell(flashWe_n) && state == S_CLRST |-> flashDataOut == 8'h50)
        else $error("clear status code wrong");
    poll_read_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        $fell(flashOe_n) |-> state == S_POLL)
        else $error("read cycle outside status poll");
endmodule : flash_lock_host
`default_nettype wire

// [core/flash_lock_pkg.sv]
// constants for the flash lock-bit host sequencer
// assumes an 8-bit command/status data path on the flash bus
package flash_lock_pkg;
    localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] CMD_LOCK_SET     = 8'h01;
    localparam logic [7:0] CMD_LOCK_CLR_ALL = 8'hD0;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam int BIT_READY   = 7;
    localparam int BIT_UNLOCK  = 5;
    localparam int BIT_PROGRAM = 4;
    localparam int BIT_SUPPLY  = 3;
    localparam int BIT_PROTECT = 1;
    localparam int ADDR_W = 22;
    // bus cycle phase lengths at 50 MHz
    localparam int PHASE_NS     = 120;
    localparam int CLK_NS       = 20;
    localparam int PHASE_CYCLES = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYCLES - 1);
    // operation codes from the user side
    localparam logic [1:0] OP_SET_LOCK   = 2'h0;
    localparam logic [1:0] OP_CLEAR_ALL  = 2'h1;
    localparam logic [1:0] OP_CLEAR_STAT = 2'h2;
    localparam logic [1:0] OP_READ_ARRAY = 2'h3;
endpackage : flash_lock_pkg

// [core/flash_cycle_if.sv]
// carrier between sequencer and bus cycle engine
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
    logic        req;
    logic        isWrite;
    logic [21:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;
    modport seq (output req, isWrite, addr, wdata, input done, rdata);
    modport eng (input req, isWrite, addr, wdata, output done, rdata);
endinterface : flash_cycle_if
`default_nettype wire

// [core/flash_bus_cycle.sv]
// one asynchronous read or write cycle on the flash pins
// assumes data pins pass two flops before use
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
    import flash_lock_pkg::*;
(
    // clock and reset
    input  wire logic    clk_sys,
    input  wire logic    nrst,
    // sequencer side
    flash_cycle_if.eng   cyc,
    // flash pins
    output logic [21:0]  flashAddr,
    output logic         flashCe_n,
    output logic         flashWe_n,
    output logic         flashOe_n,
    input  wire logic [7:0] flashDataIn,
    output logic [7:0]   flashDataOut,
    output logic         flashDataOe
);
    import flash_lock_pkg::*;
    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_ACT  = 3'b010,
        C_REC  = 3'b100
    } cyc_e;
    cyc_e       state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] syncA, syncB, rdata, next_rdata;
    logic [21:0] next_addr;
    logic [7:0] next_dout;
    logic       isWr, next_isWr;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_rdata = rdata;
        next_addr  = flashAddr;
        next_dout  = flashDataOut;
        next_isWr  = isWr;
        cyc.done   = 1'b0;
        case (state)
            C_IDLE: begin
                if (cyc.req) begin
                    next_state = C_ACT;
                    next_cnt   = 4'h0;
                    next_addr  = cyc.addr;
                    next_dout  = cyc.wdata;
                    next_isWr  = cyc.isWrite;
                end
            end
            C_ACT: begin
                next_cnt = cnt + 4'h1;
                if (cnt == PHASE_LAST) begin
                    next_state = C_REC;
                    next_cnt   = 4'h0;
                    next_rdata = syncB;
                end
            end
            C_REC: begin
                next_cnt = cnt + 4'h1;
                if (cnt == PHASE_LAST) begin
                    next_state = C_IDLE;
                    cyc.done   = 1'b1;
                end
            end
            default: next_state = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state        <= C_IDLE;
            cnt          <= 4'h0;
            rdata        <= 8'h00;
            syncA        <= 8'h00;
            syncB        <= 8'h00;
            flashAddr    <= '0;
            flashDataOut <= 8'h00;
            isWr         <= 1'b0;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            rdata        <= next_rdata;
            syncA        <= flashDataIn;
            syncB        <= syncA;
            flashAddr    <= next_addr;
            flashDataOut <= next_dout;
            isWr         <= next_isWr;
        end
    end

    assign cyc.rdata   = rdata;
    assign flashCe_n   = (state != C_ACT);
    assign flashWe_n   = !((state == C_ACT) && isWr);
    assign flashOe_n   = !((state == C_ACT) && !isWr);
    assign flashDataOe = (state != C_IDLE) && isWr;
endmodule : flash_bus_cycle
`default_nettype wire

// [dv/flash_dev_model.sv]
// behavioural flash device: command decode, sticky status, block locks
// assumes pins from flash_lock_host; faults injected by the testbench
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
    import flash_lock_pkg::*;
(
    // flash pins
    input  wire logic [21:0] flashAddr,
    input  wire logic        flashCe_n,
    input  wire logic        flashWe_n,
    input  wire logic        flashOe_n,
    input  wire logic [7:0]  flashDataOut,
    output logic [7:0]       flashDataIn,
    // test controls and views
    input  wire logic        wpLow,
    input  wire logic [7:0]  faultInj,
    input  wire logic [3:0]  busyReads,
    output logic [7:0]       lastCmd,
    output logic             arrayMode,
    output logic [63:0]      lockBits
);
    import flash_lock_pkg::*;
    logic [7:0] sr = 8'h80;
    logic       setupSeen = 1'b0;
    logic [3:0] busyCnt = 4'h0;
    logic [7:0] held = 8'h00;
    logic [7:0] rdVal;
    logic       wrAct, rdAct;
    logic       wrOpen = 1'b0;
    logic       rdOpen = 1'b0;
    initial begin
        lastCmd = 8'h00;
        arrayMode = 1'b1;
        lockBits = '0;
    end
    assign rdVal = arrayMode ? 8'h3C : {busyCnt == 4'h0, sr[6:0]};
    assign wrAct = !flashCe_n && !flashWe_n;
    assign rdAct = !flashCe_n && !flashOe_n;
    // released bus shows inverted last value
    assign flashDataIn = rdAct ? rdVal : ~held;
    // cycle ends on whichever of select or strobe rises first
    always @(posedge rdAct) rdOpen = 1'b1;
    always @(negedge rdAct) begin
        if (rdOpen) begin
            rdOpen = 1'b0;
            held = rdVal;
            if (!arrayMode && busyCnt != 4'h0) busyCnt--;
        end
    end
    always @(posedge wrAct) wrOpen = 1'b1;
    always @(negedge wrAct) begin
        if (wrOpen) begin
            wrOpen = 1'b0;
            lastCmd = flashDataOut;
            arrayMode = 1'b0;
            if (setupSeen) begin
                setupSeen = 1'b0;
                busyCnt = busyReads;
                sr = sr | faultInj;
                if (flashDataOut == CMD_LOCK_SET) begin
                    if (wpLow && lockBits[flashAddr[21:16]])
                        sr[BIT_PROTECT] = 1'b1;
                    else if (faultInj == 8'h00)
                        lockBits[flashAddr[21:16]] = 1'b1;
                end else if (flashDataOut == CMD_LOCK_CLR_ALL) begin
                    if (!faultInj[BIT_UNLOCK]) lockBits = '0;
                end else begin
                    sr[5:4] = 2'b11;
                end
            end else begin
                case (flashDataOut)
                    CMD_LOCK_SETUP:   setupSeen = 1'b1;
                    CMD_CLEAR_STATUS: sr[5:1] = 5'h00;
                    CMD_READ_ARRAY:   arrayMode = 1'b1;
                    default: ;
                endcase
            end
        end
    end
endmodule : flash_dev_model
`default_nettype wire

// [dv/test_flash_lock_host.sv]
// self-checking bench for flash_lock_host against flash_dev_model
// assumes 50 MHz clock, inputs driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_flash_lock_host;
    import flash_lock_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic opValid = 1'b0;
    logic [1:0] opCode = 2'h0;
    logic [21:0] opAddr = 22'h000000;
    logic opReady, resValid, errSequence, errProgram, errUnlock;
    logic errSupply, errProtect, errPending, flashCe_n, flashWe_n;
    logic flashOe_n, flashDataOe, arrayMode;
    logic [7:0] resStatus, flashDataIn, flashDataOut, lastCmd;
    logic [21:0] flashAddr;
    logic [63:0] lockBits;
    logic wpLow = 1'b0;
    logic [7:0] faultInj = 8'h00;
    logic [3:0] busyReads = 4'h0;
    int error_cnt = 0;
    int tests_run = 0;
    flash_lock_host u_dut (.clk_sys(clk_sys), .nrst(nrst),
        .opValid(opValid), .opReady(opReady), .opCode(opCode),
        .opAddr(opAddr), .resValid(resValid), .resStatus(resStatus),
        .errSequence(errSequence), .errProgram(errProgram),
        .errUnlock(errUnlock), .errSupply(errSupply),
        .errProtect(errProtect), .errPending(errPending),
        .flashAddr(flashAddr), .flashCe_n(flashCe_n),
        .flashWe_n(flashWe_n), .flashOe_n(flashOe_n),
        .flashDataIn(flashDataIn), .flashDataOut(flashDataOut),
        .flashDataOe(flashDataOe));
    flash_dev_model u_dev (.flashAddr(flashAddr), .flashCe_n(flashCe_n),
        .flashWe_n(flashWe_n), .flashOe_n(flashOe_n),
        .flashDataOut(flashDataOut), .flashDataIn(flashDataIn),
        .wpLow(wpLow), .faultInj(faultInj), .busyReads(busyReads),
        .lastCmd(lastCmd), .arrayMode(arrayMode), .lockBits(lockBits));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic run_op(input logic [1:0] code, input logic [21:0] a);
        int n;
        n = 0;
        while (opReady !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 100) begin
            error_cnt++;
            $display("[FAIL] %0t sequencer never ready", $time);
            finish_test();
        end
        opValid = 1'b1;
        opCode = code;
        opAddr = a;
        @(negedge clk_sys);
        opValid = 1'b0;
        chk(opReady === 1'b0, "operation not taken");
        n = 0;
        while (resValid !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            $display("[FAIL] %0t operation timed out", $time);
            finish_test();
        end
        faultInj = 8'h00;
    endtask : run_op
    task automatic t_lock_ok();
        busyReads = 4'h3;
        run_op(OP_SET_LOCK, 22'h051234);
        chk(resStatus === 8'h80, "ready status expected");
        chk(lockBits[5] === 1'b1 && errPending === 1'b0, "lock not set");
    endtask : t_lock_ok
    task automatic t_supply_series();
        busyReads = 4'h0;
        faultInj = 8'h08;
        run_op(OP_SET_LOCK, 22'h060000);
        chk(errSupply === 1'b1 && errPending === 1'b1, "supply flag");
        busyReads = 4'h2;
        run_op(OP_SET_LOCK, 22'h070000);
        chk(resStatus === 8'h88 && lockBits[7] === 1'b1, "flag lost");
        run_op(OP_CLEAR_STAT, 22'h000000);
        chk(resStatus === 8'h80 && errPending === 1'b0, "not cleared");
    endtask : t_supply_series
    task automatic t_clear_all();
        faultInj = 8'h20;
        run_op(OP_CLEAR_ALL, 22'h000000);
        chk(errUnlock === 1'b1 && errProgram === 1'b0
            && errSequence === 1'b0 && lockBits[5] === 1'b1, "unlock");
        run_op(OP_CLEAR_STAT, 22'h000000);
        run_op(OP_CLEAR_ALL, 22'h000000);
        chk(lockBits === 64'h0 && resStatus === 8'h80
            && arrayMode === 1'b0, "clear all");
    endtask : t_clear_all
    task automatic t_program_seq();
        faultInj = 8'h10;
        run_op(OP_SET_LOCK, 22'h010000);
        chk(errProgram === 1'b1 && errSequence === 1'b0
            && errUnlock === 1'b0, "program flag");
        run_op(OP_CLEAR_STAT, 22'h000000);
        faultInj = 8'h30;
        run_op(OP_SET_LOCK, 22'h010000);
        chk(errSequence === 1'b1 && errProgram === 1'b0
            && errUnlock === 1'b0, "sequence flag");
        run_op(OP_CLEAR_STAT, 22'h000000);
    endtask : t_program_seq
    task automatic t_protect();
        wpLow = 1'b1;
        run_op(OP_SET_LOCK, 22'h090000);
        run_op(OP_SET_LOCK, 22'h090000);
        chk(errProtect === 1'b1 && resStatus === 8'h82, "protect");
        wpLow = 1'b0;
        run_op(OP_CLEAR_STAT, 22'h000000);
        chk(errProtect === 1'b0, "protect cleared");
    endtask : t_protect
    task automatic t_read_array();
        run_op(OP_READ_ARRAY, 22'h000000);
        chk(lastCmd === 8'hFF && arrayMode === 1'b1, "read array");
        chk(flashDataOe === 1'b0 && flashWe_n === 1'b1, "bus not released");
    endtask : t_read_array
    initial begin
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        chk(opReady === 1'b1 && flashCe_n === 1'b1
            && flashDataOe === 1'b0 && resValid === 1'b0, "idle after reset");
        t_lock_ok();
        t_supply_series();
        t_clear_all();
        t_program_seq();
        t_protect();
        t_read_array();
        finish_test();
    end
endmodule : test_flash_lock_host
`default_nettype wire
